// ---- hdl/ccas_carry_cell.sv ----
// combinational carry logic and two 1-bit generators of one cell
`timescale 1ns/10ps
module ccas_carry_cell
   import ccas_pkg::*;
(
   input  wire ccas_mode_t mode,
   input  wire ccas_gsel_t gsel,
   input  wire logic       chain_carry_in,
   input  wire logic       low_gen_in_a,
   input  wire logic       low_gen_in_b,
   input  wire logic       low_gen_aux_in,
   input  wire logic       high_gen_in_a,
   input  wire logic       high_gen_in_b,
   input  wire logic       low_tap_direct_pin,
   input  wire logic       upper_tap_direct_pin,
   input  wire logic       upper_aux_direct_pin,
   output logic            low_gen_out,
   output logic            high_gen_out,
   output logic            intermediate_carry,
   output logic            chain_carry_out,
   output logic            low_gen_carry_tap,
   output logic            high_gen_carry_tap,
   output logic            signed_overflow,
   output logic            carry_result
);

   logic ga;
   logic gb;
   logic g3;
   logic f3;

   assign ga = high_gen_in_a;
   assign gb = high_gen_in_b;
   assign f3 = low_gen_aux_in;

   always_comb begin
      low_gen_out        = 1'h0;
      high_gen_out       = 1'h0;
      intermediate_carry = 1'h0;
      chain_carry_out    = 1'h0;
      signed_overflow    = 1'h0;
      carry_result       = 1'h0;
      low_gen_carry_tap  = low_tap_direct_pin;
      high_gen_carry_tap = upper_tap_direct_pin;
      g3                 = upper_aux_direct_pin;
      unique case (mode)
         sum_low_chain_mode, sum_two_bit_mode: begin
            low_gen_carry_tap  = chain_carry_in;
            low_gen_out        = low_gen_in_a ^ low_gen_in_b ^ low_gen_carry_tap;
            intermediate_carry = maj_add(low_gen_in_a, low_gen_in_b, chain_carry_in);
         end
         diff_low_chain_mode, diff_two_bit_mode: begin
            low_gen_carry_tap  = chain_carry_in;
            low_gen_out        = ~(low_gen_in_a ^ low_gen_in_b ^ low_gen_carry_tap);
            intermediate_carry = maj_sub(low_gen_in_a, low_gen_in_b, chain_carry_in);
         end
         dual_low_chain_mode, dual_two_bit_mode: begin
            low_gen_carry_tap  = chain_carry_in;
            low_gen_out        = ~(low_gen_in_a ^ low_gen_in_b ^ low_gen_carry_tap ^ f3);
            intermediate_carry = f3 ? maj_add(low_gen_in_a, low_gen_in_b, chain_carry_in)
                                    : maj_sub(low_gen_in_a, low_gen_in_b, chain_carry_in);
         end
         sum_high_pin_carry_mode, diff_high_pin_carry_mode, dual_high_pin_carry_mode: begin
            intermediate_carry = low_gen_in_a;
         end
         sum_high_chain_mode, diff_high_chain_mode, dual_high_chain_mode: begin
            intermediate_carry = chain_carry_in;
         end
         sum_high_inverted_carry_mode, diff_high_inverted_carry_mode,
         dual_high_null_carry_mode: begin
            intermediate_carry = ~f3;
         end
         diff_high_const_carry_mode: begin
            intermediate_carry = 1'h1;
         end
      endcase
      unique case (mode)
         sum_low_chain_mode, diff_low_chain_mode, dual_low_chain_mode: begin
            chain_carry_out = intermediate_carry;
            signed_overflow = intermediate_carry ^ chain_carry_in;
            carry_result    = intermediate_carry;
            unique case (gsel)
               gsel_none: begin
                  high_gen_out = 1'h0;
               end
               gsel_carry: begin
                  high_gen_carry_tap = intermediate_carry;
                  high_gen_out       = high_gen_carry_tap;
               end
               gsel_ovfl: begin
                  high_gen_carry_tap = intermediate_carry;
                  g3                 = chain_carry_in;
                  high_gen_out       = high_gen_carry_tap ^ g3;
               end
            endcase
         end
         sum_two_bit_mode, sum_high_pin_carry_mode, sum_high_chain_mode,
         sum_high_inverted_carry_mode: begin
            high_gen_carry_tap = intermediate_carry;
            high_gen_out       = ga ^ gb ^ high_gen_carry_tap;
            chain_carry_out    = maj_add(ga, gb, intermediate_carry);
         end
         diff_two_bit_mode, diff_high_chain_mode, diff_high_pin_carry_mode,
         diff_high_inverted_carry_mode: begin
            high_gen_carry_tap = intermediate_carry;
            high_gen_out       = ~(ga ^ gb ^ high_gen_carry_tap);
            chain_carry_out    = maj_sub(ga, gb, intermediate_carry);
         end
         diff_high_const_carry_mode: begin
            high_gen_out    = ga ^ gb;
            chain_carry_out = ga | ~gb;
         end
         dual_two_bit_mode, dual_high_chain_mode, dual_high_pin_carry_mode: begin
            high_gen_carry_tap = intermediate_carry;
            high_gen_out       = ~(ga ^ gb ^ high_gen_carry_tap ^ g3);
            chain_carry_out    = f3 ? maj_add(ga, gb, intermediate_carry)
                                    : maj_sub(ga, gb, intermediate_carry);
         end
         dual_high_null_carry_mode: begin
            high_gen_carry_tap = intermediate_carry;
            high_gen_out       = ga ^ gb;
            chain_carry_out    = (f3 & ga & gb) | (~f3 & (ga | ~gb));
         end
      endcase
   end

endmodule : ccas_carry_cell

// ---- hdl/ccas_pkg.sv ----
// package: modes, register map and carry helpers for the carry cell
package ccas_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned MODE_W = 5;
   localparam int unsigned GSEL_W = 2;
   localparam int unsigned ST_W   = 8;

   // register byte offsets
   localparam logic [7:0] REG_MODE_OFS   = 8'h00;
   localparam logic [7:0] REG_GSEL_OFS   = 8'h04;
   localparam logic [7:0] REG_STATUS_OFS = 8'h08;

   // status register bit positions
   localparam int unsigned ST_LOW_OUT  = 0;
   localparam int unsigned ST_HIGH_OUT = 1;
   localparam int unsigned ST_ICARRY   = 2;
   localparam int unsigned ST_CHAIN_CARRY_OUT     = 3;
   localparam int unsigned ST_LOW_TAP  = 4;
   localparam int unsigned ST_HIGH_TAP = 5;
   localparam int unsigned ST_CRES     = 6;
   localparam int unsigned ST_OVFL     = 7;

   typedef enum logic [4:0] {
      sum_low_chain_mode            = 5'h00,
      sum_two_bit_mode              = 5'h01,
      sum_high_pin_carry_mode       = 5'h02,
      sum_high_chain_mode           = 5'h03,
      sum_high_inverted_carry_mode  = 5'h04,
      diff_low_chain_mode           = 5'h05,
      diff_two_bit_mode             = 5'h06,
      diff_high_const_carry_mode    = 5'h07,
      diff_high_chain_mode          = 5'h08,
      diff_high_pin_carry_mode      = 5'h09,
      diff_high_inverted_carry_mode = 5'h0A,
      dual_low_chain_mode           = 5'h0B,
      dual_two_bit_mode             = 5'h0C,
      dual_high_chain_mode          = 5'h0D,
      dual_high_pin_carry_mode      = 5'h0E,
      dual_high_null_carry_mode     = 5'h0F
   } ccas_mode_t;

   // upper generator use while only the lower half computes
   typedef enum logic [1:0] {
      gsel_none  = 2'h0,
      gsel_carry = 2'h1,
      gsel_ovfl  = 2'h2
   } ccas_gsel_t;

   localparam ccas_mode_t MODE_RST = sum_two_bit_mode;
   localparam ccas_gsel_t GSEL_RST = gsel_none;

   function automatic logic maj_add(input logic a, input logic b, input logic c);
      return (a & b) | (c & (a | b));
   endfunction : maj_add

   function automatic logic maj_sub(input logic a, input logic b, input logic c);
      return (a & ~b) | (c & (a | ~b));
   endfunction : maj_sub

   function automatic logic mode_legal(input logic [MODE_W-1:0] v);
      return v[MODE_W-1] == 1'h0;
   endfunction : mode_legal

endpackage : ccas_pkg

// ---- hdl/ccas_top.sv ----
// carry-chain add/subtract cell with an apb mode and status slave
// Behaviour
// - low add mode: sum is a^b^cin, carry is majority, passed out.
// - low-only modes: upper generator may give overflow or carry result.
// - two-bit add: both halves add, chain out is upper majority.
// - upper add with pin carry: intermediate carry equals lower pin a.
// - upper add from chain: intermediate carry is chain carry in.
// - upper add with inverted carry: intermediate carry is inverse aux.
// - low subtract: inverted xor difference, subtract carry passed out.
// - two-bit subtract: both halves subtract, upper subtract carry out.
// - lsb subtract: carry one, upper xor, out is a or not b.
// - upper subtract from chain: intermediate carry is chain carry in.
// - upper subtract with pin carry: intermediate carry is lower pin a.
// - upper subtract inverted carry: intermediate carry is inverse aux.
// - low add/subtract: aux high adds, low subtracts.
// - two-bit add/subtract: both halves follow control, upper carry too.
// - upper add/subtract from chain: carry in passes, xnor of four.
// - upper add/subtract with pin carry: intermediate carry is pin a.
// - lsb add/subtract: carry is not aux, upper xor, mixed carry out.
// - high tap is intermediate carry except in lsb subtract and low modes with gsel none; low tap is chain carry in for low and two-bit modes; else pins.
// - carry equations fixed by mode; only generator use is selectable.
`timescale 1ns/10ps
module ccas_top
   import ccas_pkg::*;
#(
   parameter int unsigned ADDR_W    = 8,
   parameter ccas_mode_t  MODE_INIT = MODE_RST
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              chain_carry_in,
   input  wire logic              low_gen_in_a,
   input  wire logic              low_gen_in_b,
   input  wire logic              low_gen_aux_in,
   input  wire logic              high_gen_in_a,
   input  wire logic              high_gen_in_b,
   input  wire logic              low_tap_direct_pin,
   input  wire logic              upper_tap_direct_pin,
   input  wire logic              upper_aux_direct_pin,
   output logic                   low_gen_out,
   output logic                   high_gen_out,
   output logic                   intermediate_carry,
   output logic                   chain_carry_out,
   output logic                   low_gen_carry_tap,
   output logic                   high_gen_carry_tap,
   output logic                   signed_overflow,
   output logic                   carry_result
);

   typedef struct packed {
      ccas_mode_t        mode;
      ccas_gsel_t        gsel;
      logic              cap;
      logic              err;
      logic [DATA_W-1:0] rdata;
   } ccas_state_t;

   localparam ccas_state_t ST_RST = '{
      mode:  MODE_INIT,
      gsel:  GSEL_RST,
      cap:   1'h0,
      err:   1'h0,
      rdata: '0
   };

   ccas_state_t       st_q;
   ccas_state_t       st_d;
   logic [DATA_W-1:0] rd_val;
   logic [ST_W-1:0]   status_vec;
   logic              hit;
   logic              sel_mode;
   logic              sel_gsel;
   logic              sel_stat;
   logic              xfer_done;

   assign sel_mode  = paddr == ADDR_W'(REG_MODE_OFS);
   assign sel_gsel  = paddr == ADDR_W'(REG_GSEL_OFS);
   assign sel_stat  = paddr == ADDR_W'(REG_STATUS_OFS);
   assign hit       = sel_mode | sel_gsel | sel_stat;
   // answer one cycle after the request is captured
   assign pready    = ce & st_q.cap;
   assign pslverr   = pready & st_q.err;
   assign prdata    = st_q.rdata;
   assign xfer_done = psel & penable & pready;

   always_comb begin
      status_vec              = '0;
      status_vec[ST_LOW_OUT]  = low_gen_out;
      status_vec[ST_HIGH_OUT] = high_gen_out;
      status_vec[ST_ICARRY]   = intermediate_carry;
      status_vec[ST_CHAIN_CARRY_OUT]     = chain_carry_out;
      status_vec[ST_LOW_TAP]  = low_gen_carry_tap;
      status_vec[ST_HIGH_TAP] = high_gen_carry_tap;
      status_vec[ST_CRES]     = carry_result;
      status_vec[ST_OVFL]     = signed_overflow;
   end

   always_comb begin
      st_d   = st_q;
      rd_val = '0;
      if (sel_mode) begin
         rd_val[MODE_W-1:0] = st_q.mode;
      end else if (sel_gsel) begin
         rd_val[GSEL_W-1:0] = st_q.gsel;
      end else if (sel_stat) begin
         rd_val[ST_W-1:0] = status_vec;
      end
      if (ce) begin
         // capture address decode and read data once per transfer
         if (psel && !st_q.cap) begin
            st_d.cap   = 1'h1;
            st_d.err   = !hit;
            st_d.rdata = pwrite ? '0 : rd_val;
         end
         if (xfer_done) begin
            st_d.cap = 1'h0;
            if (pwrite && pstrb[0] && sel_mode &&
                mode_legal(pwdata[MODE_W-1:0])) begin
               st_d.mode = ccas_mode_t'(pwdata[MODE_W-1:0]);
            end
            if (pwrite && pstrb[0] && sel_gsel &&
                pwdata[GSEL_W-1:0] != 2'h3) begin
               st_d.gsel = ccas_gsel_t'(pwdata[GSEL_W-1:0]);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ccas_carry_cell u_cell (
      .mode                 (st_q.mode),
      .gsel                 (st_q.gsel),
      .chain_carry_in       (chain_carry_in),
      .low_gen_in_a         (low_gen_in_a),
      .low_gen_in_b         (low_gen_in_b),
      .low_gen_aux_in       (low_gen_aux_in),
      .high_gen_in_a        (high_gen_in_a),
      .high_gen_in_b        (high_gen_in_b),
      .low_tap_direct_pin   (low_tap_direct_pin),
      .upper_tap_direct_pin (upper_tap_direct_pin),
      .upper_aux_direct_pin (upper_aux_direct_pin),
      .low_gen_out          (low_gen_out),
      .high_gen_out         (high_gen_out),
      .intermediate_carry   (intermediate_carry),
      .chain_carry_out      (chain_carry_out),
      .low_gen_carry_tap    (low_gen_carry_tap),
      .high_gen_carry_tap   (high_gen_carry_tap),
      .signed_overflow      (signed_overflow),
      .carry_result         (carry_result)
   );

   // checks on the datapath and the register slave
   logic       a_lo;
   logic       b_lo;
   logic       a_hi;
   logic       b_hi;
   ccas_mode_t md;

   assign a_lo = low_gen_in_a;
   assign b_lo = low_gen_in_b;
   assign a_hi = high_gen_in_a;
   assign b_hi = high_gen_in_b;
   assign md   = st_q.mode;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable && !st_q.cap && ce;
   endsequence

   sequence s_mode_wr;
      xfer_done && pwrite && pstrb[0] && sel_mode && mode_legal(pwdata[MODE_W-1:0]);
   endsequence

   AST_ADD_LOW: assert property (
      md == sum_low_chain_mode |->
         low_gen_out == (a_lo ^ b_lo ^ chain_carry_in) &&
         intermediate_carry == maj_add(a_lo, b_lo, chain_carry_in) &&
         chain_carry_out == intermediate_carry)
      else $error("low add mode result wrong");

   AST_LOW_OVFL: assert property (
      (md == diff_low_chain_mode || md == sum_low_chain_mode) && st_q.gsel == gsel_ovfl |->
         high_gen_out == (intermediate_carry ^ chain_carry_in))
      else $error("overflow output wrong");

   AST_ADD_TWO: assert property (
      md == sum_two_bit_mode |->
         high_gen_out == (a_hi ^ b_hi ^ intermediate_carry) &&
         chain_carry_out == maj_add(a_hi, b_hi, intermediate_carry))
      else $error("two-bit add upper result wrong");

   AST_PIN_CARRY: assert property (
      md == sum_high_pin_carry_mode || md == diff_high_pin_carry_mode |->
         intermediate_carry == a_lo && low_gen_out == 1'h0)
      else $error("pin carry source wrong");

   AST_INV_CARRY: assert property (
      md == sum_high_inverted_carry_mode || md == diff_high_inverted_carry_mode |->
         intermediate_carry == !low_gen_aux_in)
      else $error("inverted carry source wrong");

   AST_SUB_LOW: assert property (
      md == diff_low_chain_mode |->
         low_gen_out == !(a_lo ^ b_lo ^ chain_carry_in) &&
         chain_carry_out == maj_sub(a_lo, b_lo, chain_carry_in))
      else $error("low subtract result wrong");

   AST_SUB_TWO: assert property (
      md == diff_two_bit_mode |->
         chain_carry_out == ((a_hi & !b_hi) | (intermediate_carry & (a_hi | !b_hi))))
      else $error("two-bit subtract carry wrong");

   AST_SUB_CONST: assert property (
      md == diff_high_const_carry_mode |->
         intermediate_carry && high_gen_out == (a_hi ^ b_hi) &&
         chain_carry_out == (a_hi | !b_hi))
      else $error("lsb subtract result wrong");

   AST_DUAL_LOW: assert property (
      md == dual_low_chain_mode |->
         intermediate_carry == (low_gen_aux_in ? maj_add(a_lo, b_lo, chain_carry_in)
                                               : maj_sub(a_lo, b_lo, chain_carry_in)) &&
         low_gen_out == !(a_lo ^ b_lo ^ chain_carry_in ^ low_gen_aux_in))
      else $error("low add/subtract result wrong");

   AST_DUAL_NULL: assert property (
      md == dual_high_null_carry_mode |->
         intermediate_carry == !low_gen_aux_in && high_gen_out == (a_hi ^ b_hi))
      else $error("null carry add/subtract wrong");

   AST_TAP_ROUTE: assert property (
      md inside {sum_two_bit_mode, diff_high_chain_mode, dual_high_chain_mode} |->
         high_gen_carry_tap == intermediate_carry &&
         low_gen_carry_tap == (md == sum_two_bit_mode ? chain_carry_in : low_tap_direct_pin))
      else $error("carry tap routing wrong");

   AST_MODE_WRITE: assert property (
      s_mode_wr |=> md == $past(pwdata[MODE_W-1:0]))
      else $error("mode write not applied");

   AST_MODE_HOLD: assert property (
      !(xfer_done && pwrite && sel_mode) |=> $stable(md))
      else $error("mode changed without write");

   AST_ADD_CHAIN: assert property (
      md == sum_high_chain_mode |->
         intermediate_carry == chain_carry_in &&
         high_gen_out == (a_hi ^ b_hi ^ chain_carry_in))
      else $error("chain-fed add wrong");

   AST_SUB_CHAIN: assert property (
      md == diff_high_chain_mode |->
         intermediate_carry == chain_carry_in && low_gen_out == 1'h0 &&
         chain_carry_out == maj_sub(a_hi, b_hi, chain_carry_in))
      else $error("chain-fed subtract wrong");

   AST_SUB_PIN: assert property (
      md == diff_high_pin_carry_mode |->
         high_gen_out == !(a_hi ^ b_hi ^ a_lo) &&
         chain_carry_out == maj_sub(a_hi, b_hi, a_lo))
      else $error("pin-fed subtract wrong");

   AST_SUB_INV: assert property (
      md == diff_high_inverted_carry_mode |->
         chain_carry_out == maj_sub(a_hi, b_hi, !low_gen_aux_in))
      else $error("inverted carry subtract wrong");

   AST_DUAL_TWO: assert property (
      md == dual_two_bit_mode |->
         chain_carry_out == (low_gen_aux_in ? maj_add(a_hi, b_hi, intermediate_carry)
                                            : maj_sub(a_hi, b_hi, intermediate_carry)))
      else $error("two-bit add/subtract carry wrong");

   AST_DUAL_CHAIN: assert property (
      md == dual_high_chain_mode |->
         intermediate_carry == chain_carry_in &&
         high_gen_out == !(a_hi ^ b_hi ^ chain_carry_in ^ upper_aux_direct_pin))
      else $error("chain-fed add/subtract wrong");

   AST_DUAL_PIN: assert property (
      md == dual_high_pin_carry_mode |->
         intermediate_carry == a_lo && low_gen_out == 1'h0)
      else $error("pin-fed add/subtract wrong");

   AST_LOW_CRES: assert property (
      md inside {sum_low_chain_mode, diff_low_chain_mode, dual_low_chain_mode} &&
         st_q.gsel == gsel_carry |->
         high_gen_out == intermediate_carry && carry_result == intermediate_carry)
      else $error("carry result output wrong");

   // unmapped address answers with an error
   AST_APB_ERR: assert property (
      psel && !penable && !st_q.cap && ce && !hit ##1 pready |-> pslverr)
      else $error("unmapped access without error");

   // register slave answers one cycle after capture
   AST_APB_READY: assert property (
      s_setup ##1 ce |-> pready)
      else $error("slave did not answer");

endmodule : ccas_top

// ---- testbench/ccas_chain_nbr.sv ----
// neighbouring cells: lower carry stage and the shared add/subtract control
`timescale 1ns/10ps
module ccas_chain_nbr (
   input  wire logic nb_a,
   input  wire logic nb_b,
   input  wire logic nb_cin,
   input  wire logic ctrl,
   output logic      chain_carry_in,
   output logic      low_gen_aux_in,
   output logic      upper_aux_direct_pin
);
   // carry out of the add cell below
   assign chain_carry_in = (nb_a & nb_b) | (nb_cin & (nb_a | nb_b));
   assign low_gen_aux_in       = ctrl;
   assign upper_aux_direct_pin = ctrl;
endmodule : ccas_chain_nbr

// ---- testbench/ccas_tb_top.sv ----
// self-checking bench: apb mode setup and all carry modes at random
`timescale 1ns/10ps
module ccas_tb_top;
   import ccas_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        nb_a, nb_b, nb_cin, ctrl, la, lb, ha, hb, ltp, utp, er;
   logic        ccin, faux, gaux;
   logic [7:0]  obs, vec;
   int          miscompares, n_compared, cyc;

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   ccas_chain_nbr u_ccas_chain_nbr (.nb_a(nb_a), .nb_b(nb_b), .nb_cin(nb_cin), .ctrl(ctrl),
      .chain_carry_in(ccin), .low_gen_aux_in(faux), .upper_aux_direct_pin(gaux));

   ccas_top u_ccas_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .chain_carry_in(ccin),
      .low_gen_in_a(la), .low_gen_in_b(lb), .low_gen_aux_in(faux), .high_gen_in_a(ha),
      .high_gen_in_b(hb), .low_tap_direct_pin(ltp), .upper_tap_direct_pin(utp),
      .upper_aux_direct_pin(gaux), .low_gen_out(obs[0]), .high_gen_out(obs[1]),
      .intermediate_carry(obs[2]), .chain_carry_out(obs[3]), .low_gen_carry_tap(obs[4]),
      .high_gen_carry_tap(obs[5]), .carry_result(obs[6]), .signed_overflow(obs[7]));

   assign vec = {utp, ltp, hb, ha, ctrl, lb, la, ccin};

   function automatic logic cy_add(input logic a, input logic b, input logic c);
      return (a & b) | (c & (a | b));
   endfunction : cy_add

   function automatic logic cy_sub(input logic a, input logic b, input logic c);
      return (a & ~b) | (c & (a | ~b));
   endfunction : cy_sub

   // status-ordered outputs expected for a mode, gsel and input vector
   function automatic logic [7:0] exp_cell(input logic [4:0] m, input logic [1:0] gs,
                                           input logic [7:0] v);
      logic ci, a, b, c, ga, gb, lt, ut, f, g, ic, co, lo, two;
      {ut, lt, gb, ga, c, b, a, ci} = v;
      lo  = (m == 5'h00) || (m == 5'h05) || (m == 5'h0B);
      two = (m == 5'h01) || (m == 5'h06) || (m == 5'h0C);
      f   = 1'b0;
      case (m)
         5'h00, 5'h01: begin
            f  = a ^ b ^ ci;
            ic = cy_add(a, b, ci);
         end
         5'h05, 5'h06: begin
            f  = ~(a ^ b ^ ci);
            ic = cy_sub(a, b, ci);
         end
         5'h0B, 5'h0C: begin
            f  = ~(a ^ b ^ ci ^ c);
            ic = c ? cy_add(a, b, ci) : cy_sub(a, b, ci);
         end
         5'h03, 5'h08, 5'h0D: ic = ci;
         5'h02, 5'h09, 5'h0E: ic = a;
         5'h07: ic = 1'b1;
         default: ic = ~c;
      endcase
      case (m)
         5'h01, 5'h02, 5'h03, 5'h04: begin
            g  = ga ^ gb ^ ic;
            co = cy_add(ga, gb, ic);
         end
         5'h06, 5'h08, 5'h09, 5'h0A: begin
            g  = ~(ga ^ gb ^ ic);
            co = cy_sub(ga, gb, ic);
         end
         5'h0C, 5'h0D, 5'h0E: begin
            g  = ~(ga ^ gb ^ ic ^ c);
            co = c ? cy_add(ga, gb, ic) : cy_sub(ga, gb, ic);
         end
         5'h07: begin
            g  = ga ^ gb;
            co = ga | ~gb;
         end
         5'h0F: begin
            g  = ga ^ gb;
            co = c ? (ga & gb) : (ga | ~gb);
         end
         default: begin
            g  = (gs == 2'h1) ? ic : (gs == 2'h2) ? (ic ^ ci) : 1'b0;
            co = ic;
         end
      endcase
      return {lo & (ic ^ ci), lo & ic, (lo ? gs == 2'h0 : m == 5'h07) ? ut : ic,
              (lo | two) ? ci : lt, co, ic, g, f};
   endfunction : exp_cell

   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic check_cell(input logic [7:0] x, input logic [7:0] got);
      n_compared++;
      if (got !== x) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, x);
      end
   endtask : check_cell

   task automatic check_bus(input logic [31:0] got, input logic [31:0] x);
      n_compared++;
      if (got !== x) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, x);
      end
   endtask : check_bus

   // one apb transfer, held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic drive_rand;
      logic [9:0] r;
      r = 10'($urandom);
      @(posedge pclk);
      {utp, ltp, hb, ha, lb, la, ctrl, nb_cin, nb_b, nb_a} <= r;
      @(negedge pclk);
   endtask : drive_rand

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {nb_a, nb_b, nb_cin, ctrl, la, lb, ha, hb, ltp, utp} = '0;
      miscompares = 0;
      n_compared  = 0;
      cyc         = 0;
      void'($urandom(32'hDE02));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_MODE_OFS, 32'h0);
      check_bus(rd, 32'h00000001);
      apb(1'b0, 8'h0C, 32'h0);
      check_bus({rd[30:0], er}, 32'h00000001);
      apb(1'b1, REG_MODE_OFS, 32'h00000010);
      apb(1'b0, REG_MODE_OFS, 32'h0);
      check_bus(rd, 32'h00000001);
      apb(1'b1, REG_GSEL_OFS, 32'h00000003);
      apb(1'b0, REG_GSEL_OFS, 32'h0);
      check_bus(rd, 32'h00000000);
      for (int m = 0; m < 16; m++) begin
         for (int gs = 0; gs < 3; gs++) begin
            apb(1'b1, REG_MODE_OFS, 32'(m));
            apb(1'b1, REG_GSEL_OFS, 32'(gs));
            repeat (3) begin
               drive_rand();
               check_cell(exp_cell(5'(m), 2'(gs), vec), obs);
            end
            apb(1'b0, REG_STATUS_OFS, 32'h0);
            check_bus(rd, {24'h0, exp_cell(5'(m), 2'(gs), vec)});
            check_cell(exp_cell(5'(m), 2'(gs), vec), obs);
         end
      end
      tally_and_finish();
   end
endmodule : ccas_tb_top
